// File: uce_pkg.sv
// Purpose: Shared constants and types for the USB4 cable discovery and entry link.
// Assumes: One 250 MHz clock; message framing is done by the PD protocol layer outside.
// Notes: Field positions inside the data words are fixed here once for both ends.
package uce_pkg;
    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Sender response wait, longest time, rounded down
    localparam int unsigned RSP_TIMEOUT_NS = 27000;
    localparam int unsigned RSP_TIMEOUT_CYC = (RSP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    // Upstream port entry waits, plain defaults
    localparam int unsigned USB4_WAIT_NS = 1000000;
    localparam int unsigned USB4_WAIT_CYC = (USB4_WAIT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned AME_WAIT_NS = 1000000;
    localparam int unsigned AME_WAIT_CYC = (AME_WAIT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned RSP_LAT_CYC = 8;

    // ==========================================================
    // Field layout of data words
    // ==========================================================
    localparam int unsigned SIG_LSB = 0;
    localparam int unsigned ID_ACTIVE_BIT = 31;
    localparam int unsigned ID_SOPPP_BIT = 30;
    localparam int unsigned PTN_USB4_BIT = 24;
    localparam int unsigned MODE_SPEED_LSB = 16;
    localparam int unsigned MODE_ROUNDED_LSB = 19;
    localparam int unsigned EUDO_MODE_LSB = 28;
    localparam int unsigned EUDO_SPEED_LSB = 21;
    localparam int unsigned EUDO_TYPE_LSB = 19;
    localparam logic [2:0] SIG_GEN1 = 3'h1;
    localparam logic [2:0] SIG_GEN2 = 3'h2;
    localparam logic [2:0] SIG_GEN3 = 3'h3;
    localparam logic [2:0] SPEED_GEN3 = 3'h3;
    localparam logic [2:0] EUSB_MODE_USB4 = 3'h2;
    // Arbitrary value standing in for the legacy vendor identifier
    localparam logic [15:0] LEGACY_SVID = 16'hA5C3;

    // ==========================================================
    // Message encodings
    // ==========================================================
    typedef enum logic [2:0] {
        CMD_DISC_ID,
        CMD_DISC_SVID,
        CMD_DISC_MODES,
        CMD_ENTER_MODE,
        CMD_ENTER_USB,
        CMD_DATA_RESET
    } uce_cmd_t;

    typedef enum logic [1:0] {
        TGT_SOP,
        TGT_SOP_P,
        TGT_SOP_PP
    } uce_tgt_t;

    typedef enum logic [1:0] {
        RES_NONE,
        RES_USB2,
        RES_USB3,
        RES_USB4
    } uce_res_t;
endpackage

// File: uce_msg_if.sv
// Purpose: Message channel between the downstream port and its cable and port partner.
// Assumes: Both ends share CLK_IN; a request is a one-cycle strobe, an answer likewise.
// Notes: No answer at all means the addressed responder is absent.
`timescale 1ns/1ps
interface uce_msg_if;
    import uce_pkg::*;
    logic req_valid;
    uce_tgt_t req_tgt;
    uce_cmd_t req_cmd;
    logic [31:0] req_data;
    logic rsp_valid;
    logic rsp_ack;
    logic [31:0] rsp_data;

    modport dfp (
        output req_valid, req_tgt, req_cmd, req_data,
        input rsp_valid, rsp_ack, rsp_data
    );
    modport ufp (
        input req_valid, req_tgt, req_cmd, req_data,
        output rsp_valid, rsp_ack, rsp_data
    );
endinterface

// File: uce_dfp_seq.sv
// Purpose: Downstream port sequencer for USB4 cable discovery, entry and data reset exit.
// Assumes: CONTRACT_IN and the request inputs come from logic on CLK_IN.
// Notes: One request outstanding at a time; each waits for an answer or the response timer.
`timescale 1ns/1ps
module uce_dfp_seq import uce_pkg::*; #(
    parameter int unsigned RSP_TIMEOUT = RSP_TIMEOUT_CYC
) (
    input wire logic CLK_IN, // 250 MHz clock
    input wire logic SYS_RST_IN, // Synchronous reset, high
    input wire logic CONTRACT_IN, // Explicit contract in place
    input wire logic GEN3_CAP_IN, // Port supports Gen3
    input wire logic ROUNDED_EN_IN, // Accept rounded-rate active cables
    input wire logic DATA_RESET_REQ_IN, // Pulse: request data reset
    uce_msg_if.dfp MSG_IF, // Message channel
    output logic USB4_ACTIVE_OUT, // USB4 entered
    output logic USB4_GEN3_OUT, // Gen3 permitted
    output logic FALLBACK_USB2_OUT, // Legacy USB 2.0 flow
    output logic FALLBACK_USB3_OUT, // Legacy USB 3.2 and 2.0 flow
    output logic BUSY_OUT // Discovery or reset running
);
    // ==========================================================
    // State
    typedef enum logic [3:0] {
        S_IDLE,
        S_CBL_ID,
        S_SVID,
        S_MODES,
        S_ENTER_MODE,
        S_PTN_ID,
        S_EUSB_P,
        S_EUSB_PP,
        S_EUSB_SOP,
        S_ACTIVE,
        S_DRST,
        S_DONE
    } uce_dfp_st_t;
    typedef struct packed {
        uce_dfp_st_t st;
        logic pend;
        logic req;
        uce_cmd_t cmd;
        uce_tgt_t tgt;
        logic [31:0] data;
        logic [31:0] tmr;
        logic active;
        logic pp;
        logic gen3;
        uce_res_t res;
    } uce_dfp_state_t;
    localparam uce_dfp_state_t RST_VAL = '{st: S_IDLE, pend: 1'b0, req: 1'b0, cmd: CMD_DISC_ID,
        tgt: TGT_SOP, data: 32'h0000_0000, tmr: 32'h0000_0000, active: 1'b0, pp: 1'b0,
        gen3: 1'b0, res: RES_NONE};
    uce_dfp_state_t q;
    uce_dfp_state_t d;
    logic ok;
    logic done;
    logic [2:0] sig;
    logic [2:0] speed;
    logic [1:0] rounded;
    // ==========================================================
    // Helpers
    function automatic uce_dfp_state_t issue(uce_dfp_state_t x, uce_dfp_st_t s, uce_cmd_t c,
                                             uce_tgt_t t, logic [31:0] w);
        x.st = s;
        x.pend = 1'b1;
        x.req = 1'b1;
        x.cmd = c;
        x.tgt = t;
        x.data = w;
        x.tmr = 32'(RSP_TIMEOUT - 1);
        return x;
    endfunction
    function automatic uce_dfp_state_t finish(uce_dfp_state_t x, uce_res_t r);
        x.st = S_DONE;
        x.pend = 1'b0;
        x.res = r;
        return x;
    endfunction
    // Enter_USB object: USB4 mode plus cable capabilities
    function automatic logic [31:0] eudo(logic g3, logic act);
        logic [31:0] w = 32'h0000_0000;
        w[EUDO_MODE_LSB +: 3] = EUSB_MODE_USB4;
        w[EUDO_SPEED_LSB +: 3] = g3 ? SIG_GEN3 : SIG_GEN2;
        w[EUDO_TYPE_LSB +: 2] = {1'b0, act};
        return w;
    endfunction

    function automatic logic has_legacy(logic [31:0] w);
        return (w[15:0] == LEGACY_SVID) || (w[31:16] == LEGACY_SVID);
    endfunction
    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.req = 1'b0;
        ok = MSG_IF.rsp_valid & MSG_IF.rsp_ack;
        // A nak or an expired timer both mean no usable answer
        done = q.pend & (MSG_IF.rsp_valid | (q.tmr == 32'h0000_0000));
        sig = MSG_IF.rsp_data[SIG_LSB +: 3];
        speed = MSG_IF.rsp_data[MODE_SPEED_LSB +: 3];
        rounded = MSG_IF.rsp_data[MODE_ROUNDED_LSB +: 2];
        if (q.pend && !done) begin
            d.tmr = q.tmr - 32'h0000_0001;
        end
        // Answered branches below issue, which sets pend, or finish, which clears it; S_DRST reloads RST_VAL
        case (q.st)
            S_IDLE: begin
                if (CONTRACT_IN) begin
                    d = issue(q, S_CBL_ID, CMD_DISC_ID, TGT_SOP_P, 32'h0000_0000);
                end
            end
            S_CBL_ID: begin
                if (done) begin
                    if (!ok) begin
                        d = finish(d, RES_USB2);
                    end else begin
                        d.active = MSG_IF.rsp_data[ID_ACTIVE_BIT];
                        d.pp = MSG_IF.rsp_data[ID_SOPPP_BIT];
                        if (MSG_IF.rsp_data[ID_ACTIVE_BIT]) begin
                            if (sig >= SIG_GEN2) begin
                                d.gen3 = (sig == SIG_GEN3);
                                d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                            end else if (ROUNDED_EN_IN) begin
                                d = issue(d, S_SVID, CMD_DISC_SVID, TGT_SOP_P, 32'h0000_0000);
                            end else begin
                                d = finish(d, RES_USB3);
                            end
                        end else if (sig == SIG_GEN3) begin
                            d.gen3 = 1'b1;
                            d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                        end else if (sig == SIG_GEN2 && GEN3_CAP_IN) begin
                            d = issue(d, S_SVID, CMD_DISC_SVID, TGT_SOP_P, 32'h0000_0000);
                        end else if (sig == SIG_GEN2 || sig == SIG_GEN1) begin
                            d.gen3 = 1'b0;
                            d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                        end else begin
                            d = finish(d, RES_USB3);
                        end
                    end
                end
            end
            S_SVID: begin
                if (done) begin
                    if (ok && has_legacy(MSG_IF.rsp_data)) begin
                        d = issue(d, S_MODES, CMD_DISC_MODES, TGT_SOP_P, {16'h0000, LEGACY_SVID});
                    end else if (!q.active) begin
                        // Not a legacy cable, still a Gen2 passive one
                        d.gen3 = 1'b0;
                        d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                    end else begin
                        d = finish(d, RES_USB3);
                    end
                end
            end
            S_MODES: begin
                if (done) begin
                    d.gen3 = ok && (speed == SPEED_GEN3);
                    if (!q.active) begin
                        d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                    end else if (ok && rounded != 2'h0) begin
                        d = issue(d, S_ENTER_MODE, CMD_ENTER_MODE, TGT_SOP_P, {16'h0000, LEGACY_SVID});
                    end else begin
                        d = finish(d, RES_USB3);
                    end
                end
            end
            S_ENTER_MODE: begin
                if (done) begin
                    if (ok) begin
                        d = issue(d, S_PTN_ID, CMD_DISC_ID, TGT_SOP, 32'h0000_0000);
                    end else begin
                        d = finish(d, RES_USB3);
                    end
                end
            end
            S_PTN_ID: begin
                if (done) begin
                    if (ok && MSG_IF.rsp_data[PTN_USB4_BIT]) begin
                        d = issue(d, S_EUSB_P, CMD_ENTER_USB, TGT_SOP_P, eudo(q.gen3, q.active));
                    end else begin
                        d = finish(d, RES_USB3);
                    end
                end
            end
            S_EUSB_P: begin
                if (done) begin
                    if (!ok) begin
                        d = finish(d, RES_USB3);
                    end else if (q.pp) begin
                        d = issue(d, S_EUSB_PP, CMD_ENTER_USB, TGT_SOP_PP, eudo(q.gen3, q.active));
                    end else begin
                        d = issue(d, S_EUSB_SOP, CMD_ENTER_USB, TGT_SOP, eudo(q.gen3, q.active));
                    end
                end
            end
            S_EUSB_PP: begin
                if (done) begin
                    if (ok) begin
                        d = issue(d, S_EUSB_SOP, CMD_ENTER_USB, TGT_SOP, eudo(q.gen3, q.active));
                    end else begin
                        d = finish(d, RES_USB3);
                    end
                end
            end
            S_EUSB_SOP: begin
                if (done) begin
                    d = finish(d, ok ? RES_USB4 : RES_USB3);
                    d.st = ok ? S_ACTIVE : S_DONE;
                end
            end
            S_ACTIVE, S_DONE: begin
                // Contract renegotiation does not disturb this state
                if (DATA_RESET_REQ_IN) begin
                    d = issue(q, S_DRST, CMD_DATA_RESET, TGT_SOP, 32'h0000_0000);
                    d.res = RES_NONE;
                end
            end
            S_DRST: begin
                // Answered or not, rediscover from scratch; contract untouched
                if (done) begin
                    d = RST_VAL;
                end
            end
            default: begin
                d = RST_VAL;
            end
        endcase
        // Losing the contract abandons everything
        if (!CONTRACT_IN) begin
            d = RST_VAL;
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end
    // ==========================================================
    // Outputs
    assign MSG_IF.req_valid = q.req;
    assign MSG_IF.req_tgt = q.tgt;
    assign MSG_IF.req_cmd = q.cmd;
    assign MSG_IF.req_data = q.data;
    assign USB4_ACTIVE_OUT = (q.res == RES_USB4);
    assign USB4_GEN3_OUT = (q.res == RES_USB4) & q.gen3;
    assign FALLBACK_USB2_OUT = (q.res == RES_USB2);
    assign FALLBACK_USB3_OUT = (q.res == RES_USB3);
    assign BUSY_OUT = q.pend;
endmodule

// File: uce_ufp_resp.sv
// Purpose: Far end of the message channel: cable responders and upstream port partner.
// Assumes: Answers come a fixed latency after each request; absent responders stay silent.
// Notes: Entry wait timers run from reset and from each data reset.
`timescale 1ns/1ps
module uce_ufp_resp import uce_pkg::*; #(
    parameter int unsigned RSP_LAT = RSP_LAT_CYC,
    parameter int unsigned USB4_WAIT = USB4_WAIT_CYC,
    parameter int unsigned AME_WAIT = AME_WAIT_CYC
) (
    input wire logic CLK_IN, // 250 MHz clock
    input wire logic SYS_RST_IN, // Synchronous reset, high
    uce_msg_if.ufp MSG_IF, // Message channel
    input wire logic CABLE_PRESENT_IN, // SOP' responder present
    input wire logic SOPPP_PRESENT_IN, // SOP'' responder present
    input wire logic [31:0] CABLE_ID_VDO_IN, // Cable identity word
    input wire logic [15:0] CABLE_SVID_IN, // Cable vendor id list entry
    input wire logic [31:0] CABLE_MODES_VDO_IN, // Cable modes word
    input wire logic PARTNER_USB4_IN, // Partner is USB4 capable
    output logic USB4_ENTERED_OUT, // USB4 entered at SOP
    output logic CABLE_MODE_ENTERED_OUT, // Cable mode entered
    output logic USB4_WAIT_EXPIRED_OUT, // usb4_entry_wait_timer ran out
    output logic ALTMODE_WAIT_EXPIRED_OUT, // altmode_entry_wait_timer ran out
    output logic DATA_RESET_SEEN_OUT, // Pulse: data reset taken
    output logic [31:0] ENTER_USB_DO_OUT // Last Enter_USB object at SOP
);
    typedef struct packed {
        logic pend;
        logic [7:0] cnt;
        uce_cmd_t cmd;
        uce_tgt_t tgt;
        logic [31:0] data;
        logic rsp;
        logic [31:0] rdata;
        logic usb4;
        logic cmode;
        logic [31:0] ut;
        logic [31:0] at;
        logic uexp;
        logic aexp;
        logic drst;
        logic [31:0] eudo;
    } uce_ufp_state_t;

    localparam uce_ufp_state_t RST_VAL = '{pend: 1'b0, cnt: 8'h00, cmd: CMD_DISC_ID, tgt: TGT_SOP,
        data: 32'h0000_0000, rsp: 1'b0, rdata: 32'h0000_0000, usb4: 1'b0, cmode: 1'b0,
        ut: 32'(USB4_WAIT), at: 32'(AME_WAIT), uexp: 1'b0, aexp: 1'b0, drst: 1'b0,
        eudo: 32'h0000_0000};

    uce_ufp_state_t q;
    uce_ufp_state_t d;
    logic present;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d = q;
        d.rsp = 1'b0;
        d.drst = 1'b0;
        present = (MSG_IF.req_tgt == TGT_SOP) || (MSG_IF.req_tgt == TGT_SOP_P && CABLE_PRESENT_IN) ||
            (MSG_IF.req_tgt == TGT_SOP_PP && SOPPP_PRESENT_IN);
        if (MSG_IF.req_valid && !q.pend && present) begin
            d.pend = 1'b1;
            d.cnt = 8'(RSP_LAT - 1);
            d.cmd = MSG_IF.req_cmd;
            d.tgt = MSG_IF.req_tgt;
            d.data = MSG_IF.req_data;
        end
        if (q.pend) begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h00) begin
                d.pend = 1'b0;
                d.rsp = 1'b1;
                d.rdata = 32'h0000_0000;
                case (q.cmd)
                    CMD_DISC_ID: begin
                        // The partner at SOP answers with its USB4 bit; the cable answers with its identity word
                        if (q.tgt == TGT_SOP) begin
                            d.rdata[PTN_USB4_BIT] = PARTNER_USB4_IN;
                        end else begin
                            d.rdata = CABLE_ID_VDO_IN;
                        end
                    end
                    CMD_DISC_SVID: d.rdata = {16'h0000, CABLE_SVID_IN};
                    CMD_DISC_MODES: d.rdata = CABLE_MODES_VDO_IN;
                    CMD_ENTER_MODE: d.cmode = 1'b1;
                    CMD_ENTER_USB: begin
                        if (q.tgt == TGT_SOP) begin
                            d.usb4 = (q.data[EUDO_MODE_LSB +: 3] == EUSB_MODE_USB4);
                            d.eudo = q.data;
                        end
                    end
                    CMD_DATA_RESET: begin
                        // Data paths and modes drop; power and roles are not held here
                        d.usb4 = 1'b0;
                        d.cmode = 1'b0;
                        d.drst = 1'b1;
                        d.ut = 32'(USB4_WAIT);
                        d.at = 32'(AME_WAIT);
                        d.uexp = 1'b0;
                        d.aexp = 1'b0;
                    end
                    default: d.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Entry waits stop once the matching entry arrives
        if (!d.drst) begin
            if (!q.usb4 && !q.uexp) begin
                d.ut = q.ut - 32'h0000_0001;
                d.uexp = (q.ut == 32'h0000_0001);
            end
            if (!q.cmode && !q.aexp) begin
                d.at = q.at - 32'h0000_0001;
                d.aexp = (q.at == 32'h0000_0001);
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign MSG_IF.rsp_valid = q.rsp;
    assign MSG_IF.rsp_ack = q.rsp;
    assign MSG_IF.rsp_data = q.rdata;
    assign USB4_ENTERED_OUT = q.usb4;
    assign CABLE_MODE_ENTERED_OUT = q.cmode;
    assign USB4_WAIT_EXPIRED_OUT = q.uexp;
    assign ALTMODE_WAIT_EXPIRED_OUT = q.aexp;
    assign DATA_RESET_SEEN_OUT = q.drst;
    assign ENTER_USB_DO_OUT = q.eudo;
endmodule

// File: uce_disc_props.sv
// Purpose: Checks on the message channel between the downstream port and its far end.
// Assumes: Contract stays high while requests are in flight.
// Notes: Sees only the interface signals; bounds come from the hand-over latencies.
`timescale 1ns/1ps
module uce_disc_props import uce_pkg::*; (
    input wire logic CLK_IN, // Clock
    input wire logic SYS_RST_IN, // Reset, high
    input wire logic req_valid, // Request strobe
    input wire uce_tgt_t req_tgt, // Target
    input wire uce_cmd_t req_cmd, // Command
    input wire logic [31:0] req_data, // Request word
    input wire logic rsp_valid, // Answer strobe
    input wire logic rsp_ack, // Answer is ack
    input wire logic [31:0] rsp_data // Answer word
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_id; rsp_valid && rsp_ack && req_cmd == CMD_DISC_ID && req_tgt == TGT_SOP_P; endsequence
    sequence s_svid; rsp_valid && rsp_ack && req_cmd == CMD_DISC_SVID; endsequence
    // Answer needs nine cycles, so no second request inside eight
    property p_gap; req_valid |=> !req_valid [*8]; endproperty
    a_gap: assert property (p_gap) else $error("request while one pending");
    property p_g3; (s_id ##0 rsp_data[2:0] == SIG_GEN3) |=> req_valid && req_tgt == TGT_SOP; endproperty
    a_g3: assert property (p_g3) else $error("gen3 cable not accepted");
    property p_svid; (s_svid ##0 rsp_data[15:0] == LEGACY_SVID) |=> req_cmd == CMD_DISC_MODES
        && req_data[15:0] == LEGACY_SVID; endproperty
    a_svid: assert property (p_svid) else $error("modes query missing");
    property p_nosvid; (s_svid ##0 rsp_data[15:0] != LEGACY_SVID && rsp_data[31:16] != LEGACY_SVID)
        |=> !(req_valid && req_cmd == CMD_DISC_MODES); endproperty
    a_nosvid: assert property (p_nosvid) else $error("modes query without vendor");
    property p_dr_sop; req_valid && req_cmd == CMD_DATA_RESET |-> req_tgt == TGT_SOP; endproperty
    a_dr_sop: assert property (p_dr_sop) else $error("data reset to wrong target");
    // One idle cycle after the reset answer, then the cable is asked again
    property p_restart; rsp_valid && req_cmd == CMD_DATA_RESET |-> ##2 req_valid && req_tgt == TGT_SOP_P; endproperty
    a_restart: assert property (p_restart) else $error("no rediscovery after reset");
    property p_mode; req_valid && req_cmd == CMD_ENTER_USB |-> req_data[30:28] == EUSB_MODE_USB4; endproperty
    a_mode: assert property (p_mode) else $error("entry mode field wrong");
    property p_order; rsp_valid && req_cmd == CMD_ENTER_USB && req_tgt == TGT_SOP_P
        |=> req_valid && req_cmd == CMD_ENTER_USB && req_tgt != TGT_SOP_P; endproperty
    a_order: assert property (p_order) else $error("entry order wrong");
    c_usb4: cover property (rsp_valid && req_cmd == CMD_ENTER_USB && req_tgt == TGT_SOP);
    c_reset: cover property (rsp_valid && req_cmd == CMD_DATA_RESET);
    c_mode: cover property (rsp_valid && req_cmd == CMD_ENTER_MODE);
endmodule

// File: usb4_cable_discovery_entry_tb_top.sv
// Purpose: Self-checking bench joining both ends of the discovery link.
// Assumes: Short response timer and entry waits keep the run brief.
// Notes: Every run resets both ends; inputs change 1 ns after a rising edge.
`timescale 1ns/1ps
module usb4_cable_discovery_entry_tb_top;
    import uce_pkg::*;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; $display("wrong value %s exp %0h seen %0h", n, e, s); end end
    int n_errors = 0, num_checks = 0;
    logic clk = 1'h0, rst = 1'h1, ctr = 1'h1, g3c = 1'h0, ren = 1'h0, drq = 1'h0, cab = 1'h0, spp = 1'h0, pu = 1'h0;
    logic [31:0] idv = 32'h0, mdv = 32'h0, eudo;
    logic [15:0] sv = 16'h0;
    logic act, g3, fb2, fb3, busy, ent, cme, uwx, awx, drs;
    wire logic [3:0] res = {act, g3, fb2, fb3};
    uce_msg_if msg_if ();
    uce_dfp_seq #(.RSP_TIMEOUT(32)) u_uce_dfp_seq (.CLK_IN(clk), .SYS_RST_IN(rst), .CONTRACT_IN(ctr), .GEN3_CAP_IN(g3c),
        .ROUNDED_EN_IN(ren), .DATA_RESET_REQ_IN(drq), .MSG_IF(msg_if), .USB4_ACTIVE_OUT(act), .USB4_GEN3_OUT(g3),
        .FALLBACK_USB2_OUT(fb2), .FALLBACK_USB3_OUT(fb3), .BUSY_OUT(busy));
    uce_ufp_resp #(.USB4_WAIT(100), .AME_WAIT(100)) u_uce_ufp_resp (.CLK_IN(clk), .SYS_RST_IN(rst), .MSG_IF(msg_if),
        .CABLE_PRESENT_IN(cab), .SOPPP_PRESENT_IN(spp), .CABLE_ID_VDO_IN(idv), .CABLE_SVID_IN(sv),
        .CABLE_MODES_VDO_IN(mdv), .PARTNER_USB4_IN(pu), .USB4_ENTERED_OUT(ent), .CABLE_MODE_ENTERED_OUT(cme),
        .USB4_WAIT_EXPIRED_OUT(uwx), .ALTMODE_WAIT_EXPIRED_OUT(awx), .DATA_RESET_SEEN_OUT(drs), .ENTER_USB_DO_OUT(eudo));
    uce_disc_props u_uce_disc_props (.CLK_IN(clk), .SYS_RST_IN(rst), .req_valid(msg_if.req_valid),
        .req_tgt(msg_if.req_tgt), .req_cmd(msg_if.req_cmd), .req_data(msg_if.req_data), .rsp_valid(msg_if.rsp_valid),
        .rsp_ack(msg_if.rsp_ack), .rsp_data(msg_if.rsp_data));
    initial forever #2 clk = ~clk;
    // Flags are cable, second marker, gen3 port, rounded accept, partner
    task automatic run(input logic [31:0] i, input logic [15:0] s, input logic [31:0] m, input logic [4:0] f);
        int n;
        {idv, sv, mdv, cab, spp, g3c, ren, pu} = {i, s, m, f};
        rst = 1'h1;
        repeat (4) #4;
        rst = 1'h0;
        for (n = 0; n < 500 && res == 4'h0; n++) #4;
    endtask
    task automatic s_passive;
        run(32'h40000003, 16'h0, 32'h0, 5'h1D);
        `CHK("passive gen3", 4'hC, res)
        `CHK("entry mode", 3'h2, eudo[30:28])
        run(32'h2, LEGACY_SVID, 32'h00030000, 5'h15);
        `CHK("legacy passive", 4'hC, res)
        run(32'h2, 16'h1234, 32'h0, 5'h15);
        `CHK("plain gen2 passive", 4'h8, res)
        run(32'h1, 16'h0, 32'h0, 5'h11);
        `CHK("gen1 passive", 4'h8, res)
    endtask
    task automatic s_active;
        run(32'h80000003, 16'h0, 32'h0, 5'h15);
        `CHK("active gen3", 4'hC, res)
        run(32'h80000001, 16'h0, 32'h0, 5'h15);
        `CHK("active gen1", 4'h1, res)
        run(32'h80000001, LEGACY_SVID, 32'h00080000, 5'h17);
        `CHK("rounded active", 5'h11, {res, cme})
        run(32'h0, 16'h0, 32'h0, 5'h05);
        `CHK("no cable", 4'h2, res)
        run(32'h3, 16'h0, 32'h0, 5'h14);
        `CHK("no partner", 5'h2, {res, ent})
        run(32'h0, 16'h0, 32'h0, 5'h15);
        `CHK("unrated passive", 4'h1, res)
        run(32'h80000001, LEGACY_SVID, 32'h00030000, 5'h17);
        `CHK("active without rounded", 5'h02, {res, cme})
    endtask
    task automatic s_idle_reset;
        int n;
        ctr = 1'h0;
        run(32'h3, 16'h0, 32'h0, 5'h15);
        `CHK("idle without contract", 6'h1, {busy, res, uwx})
        ctr = 1'h1;
        run(32'h3, 16'h0, 32'h0, 5'h15);
        // Let the altmode wait run out so its restart is visible
        repeat (80) #4;
        `CHK("altmode wait ran out", 1'h1, awx)
        drq = 1'h1;
        #4;
        drq = 1'h0;
        for (n = 0; n < 100 && drs !== 1'h1; n++) #4;
        `CHK("usb4 during reset", 2'h1, {act, drs})
        `CHK("far end left usb4", 2'h0, {ent, cme})
        `CHK("altmode wait restarted", 1'h0, awx)
        for (n = 0; n < 500 && act !== 1'h1; n++) #4;
        `CHK("rerun result", 4'hC, res)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #3;
        s_passive();
        s_active();
        s_idle_reset();
        tally_and_finish();
    end
    // Far above the longest expected run
    initial begin
        #60000;
        n_errors++;
        tally_and_finish();
    end
endmodule
